// [hw/cmb_pkg.sv]
`default_nettype none

// ==========================================================
// Message buffer store: shared constants and types
// ==========================================================
package cmb_pkg;

	// ==========================================================
	// Storage geometry
	// ==========================================================
	localparam int unsigned CMB_NUM_TX       = 3;
	localparam int unsigned CMB_TX_BYTES     = 16;
	localparam int unsigned CMB_FRAME_BYTES  = 13;
	localparam int unsigned CMB_LOCAL_PRIORITY_FIELD_BYTE    = 13;
	localparam int unsigned CMB_TX_TS_HI     = 14;
	localparam int unsigned CMB_TX_TS_LO     = 15;
	localparam int unsigned CMB_RX_DEPTH     = 5;
	localparam int unsigned CMB_RX_BYTES     = 15;
	localparam int unsigned CMB_RX_TS_HI     = 13;
	localparam int unsigned CMB_RX_TS_LO     = 14;

	// ==========================================================
	// Register byte offsets
	// ==========================================================
	localparam logic [7:0] CMB_TXWIN_BASE    = 8'h00;
	localparam logic [7:0] CMB_RXWIN_BASE    = 8'h10;
	localparam logic [7:0] CMB_TX_FLAG       = 8'h20;
	localparam logic [7:0] CMB_TX_SEL        = 8'h24;
	localparam logic [7:0] CMB_ABT_REQ       = 8'h28;
	localparam logic [7:0] CMB_ABT_ACK       = 8'h2C;
	localparam logic [7:0] CMB_RX_FLAG       = 8'h30;
	localparam logic [7:0] CMB_CTRL          = 8'h34;
	localparam logic [7:0] CMB_STATUS        = 8'h38;

	// ==========================================================
	// Control field positions and reset values
	// ==========================================================
	localparam int unsigned CMB_CTRL_LOOP    = 0;
	localparam int unsigned CMB_CTRL_TS      = 1;
	localparam int unsigned CMB_CTRL_RXIE    = 2;
	localparam int unsigned CMB_CTRL_OVIE    = 3;
	localparam int unsigned CMB_CTRL_TXIE    = 4;
	localparam int unsigned CMB_RXF_BIT      = 0;
	localparam int unsigned CMB_OVR_BIT      = 1;
	localparam logic [7:0]  CMB_CTRL_RST     = 8'h00;
	localparam logic [2:0]  CMB_TX_EMPTY_RST = 3'h7;
	localparam logic [2:0]  CMB_RX_DEPTH_W   = 3'h5;

	// ==========================================================
	// Types
	// ==========================================================
	typedef logic [7:0] cmb_byte_t;

	typedef enum logic {
		CMB_TX_IDLE = 1'b0,
		CMB_TX_SEND = 1'b1
	} cmb_tx_state_e;

endpackage

`default_nettype wire

// [hw/cmb_store.sv]
// Local design decisions: the Wishbone register port and the register offsets.
`default_nettype none

// Contract
// - Three independent transmit buffers let frames queue back to back.
// - Each transmit buffer holds 13 frame bytes, a priority byte, two stamp bytes.
// - Successful send sets the empty flag again and raises a transmit interrupt.
// - Among pending buffers the numerically lowest priority byte is sent.
// - Priority selection is redone at every arbitration, retries included.
// - Host requests abort; a frame already on the bus is never aborted.
// - Granted abort sets acknowledge and empty; acknowledge is zero after a send.
// - Five-stage receive FIFO; only the foreground stage is host visible.
// - Each receive buffer is 15 bytes including an optional stamp.
// - Receive-full flag is set while foreground holds an accepted good frame.
// - Good accepted frame moves into the FIFO, sets receive-full, interrupts.
// - A new frame may be received right after the inter-frame space.
// - Bad or rejected frames never enter the FIFO; background is overwritten.
// - Outside loopback own frames stay in background: no queue, no interrupt.
// - In loopback own frames are handled like frames from other nodes.
// - On lost arbitration the block becomes a receiver of the winning frame.
// - Accepted frame arriving with FIFO full is dropped and overrun flagged.
// - Sending continues while FIFO is full; acceptance resumes once a stage frees.
// - Equal lowest priorities resolve to the lower buffer index.
// - With stamping on, the bit timer is stored after a valid frame ends.

module cmb_store
	import cmb_pkg::*;
(
	input  wire  logic                  clk_i,
	input  wire  logic                  rst_i,
	input  wire  logic                  wb_cyc_i,
	input  wire  logic                  wb_stb_i,
	input  wire  logic                  wb_we_i,
	input  wire  logic [7:0]            wb_adr_i,
	input  wire  logic [3:0]            wb_sel_i,
	input  wire  logic [31:0]           wb_dat_i,
	output var   logic [31:0]           wb_dat_o,
	output var   logic                  wb_ack_o,
	input  wire  logic                  eng_arb_i,
	input  wire  logic                  eng_tx_done_i,
	input  wire  logic                  eng_tx_err_i,
	input  wire  logic                  eng_arb_lost_i,
	input  wire  logic [3:0]            eng_tx_rd_addr_i,
	output var   logic                  tx_busy_o,
	output var   logic [1:0]            tx_idx_o,
	output var   cmb_pkg::cmb_byte_t    tx_byte_o,
	input  wire  logic                  eng_rx_we_i,
	input  wire  logic [3:0]            eng_rx_addr_i,
	input  wire  cmb_pkg::cmb_byte_t    eng_rx_data_i,
	input  wire  logic                  eng_rx_end_i,
	input  wire  logic                  eng_rx_accept_i,
	input  wire  logic                  eng_rx_own_i,
	input  wire  logic                  eng_bit_tick_i,
	output var   logic                  tx_int_o,
	output var   logic                  rx_int_o,
	output var   logic                  ovr_int_o
);
	import cmb_pkg::*;

	// ==========================================================
	// Helper functions
	// ==========================================================
	// Lowest pending priority wins, strict compare keeps lower index on a tie
	function automatic logic [1:0] cmb_pick(input logic [2:0] pend,
		input logic [2:0][7:0] pr);
		logic [1:0] best;
		logic       found;
		best  = 2'h0;
		found = 1'b0;
		for (int i = 0; i < CMB_NUM_TX; i++) begin
			if (pend[i] && (!found || pr[i] < pr[best])) begin
				best  = 2'(i);
				found = 1'b1;
			end
		end
		return best;
	endfunction

	// Keeps only the lowest set bit of a buffer mask
	function automatic logic [2:0] cmb_lowest(input logic [2:0] m);
		logic [2:0] r;
		r = 3'h0;
		for (int i = CMB_NUM_TX - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = 3'h0;
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Storage and state
	// ==========================================================
	logic [CMB_TX_BYTES-1:0][7:0] tx_mem [CMB_NUM_TX];
	logic [CMB_RX_BYTES-1:0][7:0] rx_mem [CMB_RX_DEPTH];
	logic [CMB_RX_BYTES-1:0][7:0] bg_buf;
	logic [CMB_RX_BYTES-1:0][7:0] bg_final;
	logic [2:0]                   tx_empty;
	logic [2:0]                   abt_req;
	logic [2:0]                   abt_ack;
	logic [2:0]                   tx_sel;
	logic [7:0]                   ctrl;
	logic [15:0]                  bit_timer;
	cmb_tx_state_e                tx_state;
	logic [1:0]                   cur;
	logic [2:0]                   rx_count;
	logic [2:0]                   rd_ptr;
	logic [2:0]                   wr_ptr;
	logic                         ovr_flag;
	logic [2:0][7:0]              local_priority_field;
	logic [1:0]                   sel_idx;
	logic                         sel_ok;
	logic [31:0]                  next_rd;

	// Priority bytes of all buffers side by side for the picker
	for (genvar g = 0; g < CMB_NUM_TX; g++) begin : g_local_priority_field
		assign local_priority_field[g] = tx_mem[g][CMB_LOCAL_PRIORITY_FIELD_BYTE];
	end

	// ==========================================================
	// Bus decode
	// ==========================================================
	logic acc;
	logic wr_now;
	logic in_txwin;
	logic in_rxwin;
	logic pop;
	logic commit;
	logic push;
	logic rx_full_flag;
	logic sending;
	logic tx_done_ok;

	// Writes act on the edge where the master sees ack, so they happen once
	assign acc          = wb_cyc_i & wb_stb_i;
	assign wr_now       = acc & wb_we_i & wb_ack_o;
	assign in_txwin     = wb_adr_i[7:4] == CMB_TXWIN_BASE[7:4];
	assign in_rxwin     = wb_adr_i[7:4] == CMB_RXWIN_BASE[7:4];
	assign rx_full_flag = rx_count != 3'h0;
	assign sending      = tx_state == CMB_TX_SEND;
	assign tx_done_ok   = sending & eng_tx_done_i;

	// Clearing receive-full releases the foreground stage
	assign pop = wr_now && wb_adr_i == CMB_RX_FLAG && wb_sel_i[0]
		&& wb_dat_i[CMB_RXF_BIT] && rx_full_flag;

	// Own frames only count in loopback; bad or rejected ones never commit
	assign commit = eng_rx_end_i & eng_rx_accept_i
		& (~eng_rx_own_i | ctrl[CMB_CTRL_LOOP]);

	// A stage freed in the same cycle already makes room
	assign push = commit & ((rx_count != CMB_RX_DEPTH_W) | pop);

	// Selected buffer index and whether its window may be touched
	always_comb begin
		sel_idx = 2'h0;
		for (int i = 0; i < CMB_NUM_TX; i++) begin
			if (tx_sel[i]) begin
				sel_idx = 2'(i);
			end
		end
		sel_ok = |(tx_sel & tx_empty);
	end

	// Stamp overlay: the frame enters the FIFO with the stamp already in place
	always_comb begin
		bg_final = bg_buf;
		if (ctrl[CMB_CTRL_TS]) begin
			bg_final[CMB_RX_TS_HI] = bit_timer[15:8];
			bg_final[CMB_RX_TS_LO] = bit_timer[7:0];
		end
	end

	// ==========================================================
	// Wishbone slave
	// ==========================================================
	// Read data mux; unmapped offsets read as zero
	always_comb begin
		logic [3:0] bidx;
		next_rd = 32'h0000_0000;
		bidx    = 4'h0;
		for (int k = 0; k < 4; k++) begin
			bidx = {wb_adr_i[3:2], 2'(k)};
			if (in_txwin && sel_ok) begin
				next_rd[8*k +: 8] = tx_mem[sel_idx][bidx];
			end else if (in_rxwin && bidx < 4'(CMB_RX_BYTES)) begin
				next_rd[8*k +: 8] = rx_mem[rd_ptr][bidx];
			end
		end
		unique case (wb_adr_i)
			CMB_TX_FLAG: next_rd = {29'h0000_0000, tx_empty};
			CMB_TX_SEL:  next_rd = {29'h0000_0000, tx_sel};
			CMB_ABT_REQ: next_rd = {29'h0000_0000, abt_req};
			CMB_ABT_ACK: next_rd = {29'h0000_0000, abt_ack};
			CMB_RX_FLAG: next_rd = {30'h0000_0000, ovr_flag, rx_full_flag};
			CMB_CTRL:    next_rd = {24'h00_0000, ctrl};
			CMB_STATUS:  next_rd = {26'h000_0000, rx_count, sending, cur};
			default:     next_rd = next_rd;
		endcase
	end

	// One wait state: ack and read data rise together, ack drops next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc & ~wb_ack_o;
			wb_dat_o <= next_rd;
		end
	end

	// Control register: loopback, stamping and interrupt enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= CMB_CTRL_RST;
		end else if (wr_now && wb_adr_i == CMB_CTRL && wb_sel_i[0]) begin
			ctrl <= wb_dat_i[7:0];
		end
	end

	// Buffer select keeps only the lowest requested buffer that is empty
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_sel <= 3'h0;
		end else if (wr_now && wb_adr_i == CMB_TX_SEL && wb_sel_i[0]) begin
			tx_sel <= cmb_lowest(wb_dat_i[2:0] & tx_empty);
		end
	end

	// ==========================================================
	// Bit timer
	// ==========================================================
	// Free running on bit ticks; wraps silently, no overrun indication
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_timer <= 16'h0000;
		end else if (eng_bit_tick_i) begin
			bit_timer <= bit_timer + 16'h0001;
		end
	end

	// ==========================================================
	// Transmit side
	// ==========================================================
	// Arbitration picks afresh each time; error or lost bus returns to idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state <= CMB_TX_IDLE;
			cur      <= 2'h0;
		end else begin
			unique case (tx_state)
				CMB_TX_IDLE: begin
					if (eng_arb_i && (~tx_empty & ~abt_req) != 3'h0) begin
						cur      <= cmb_pick(~tx_empty & ~abt_req, local_priority_field);
						tx_state <= CMB_TX_SEND;
					end
				end
				CMB_TX_SEND: begin
					if (eng_tx_done_i || eng_tx_err_i || eng_arb_lost_i) begin
						tx_state <= CMB_TX_IDLE;
					end
				end
			endcase
		end
	end

	// Empty, abort request and acknowledge per buffer; hardware sets win
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_empty <= CMB_TX_EMPTY_RST;
			abt_req  <= 3'h0;
			abt_ack  <= 3'h0;
		end else begin
			for (int i = 0; i < CMB_NUM_TX; i++) begin
				if (wr_now && wb_adr_i == CMB_TX_FLAG && wb_sel_i[0]
					&& wb_dat_i[i] && tx_empty[i]) begin
					tx_empty[i] <= 1'b0;
					abt_ack[i]  <= 1'b0;
				end
				if (wr_now && wb_adr_i == CMB_ABT_REQ && wb_sel_i[0]
					&& wb_dat_i[i] && !tx_empty[i]) begin
					abt_req[i] <= 1'b1;
				end
				if (abt_req[i] && !tx_empty[i] && !(sending && cur == 2'(i))) begin
					abt_ack[i]  <= 1'b1;
					tx_empty[i] <= 1'b1;
					abt_req[i]  <= 1'b0;
				end
				if (tx_done_ok && cur == 2'(i)) begin
					tx_empty[i] <= 1'b1;
					abt_ack[i]  <= 1'b0;
					abt_req[i]  <= 1'b0;
				end
			end
		end
	end

	// Host loads the selected buffer; stamp goes in after a good send
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < CMB_NUM_TX; i++) begin
				tx_mem[i] <= '0;
			end
		end else begin
			if (wr_now && in_txwin && sel_ok) begin
				for (int k = 0; k < 4; k++) begin
					if (wb_sel_i[k] && {wb_adr_i[3:2], 2'(k)} <= 4'(CMB_LOCAL_PRIORITY_FIELD_BYTE)) begin
						tx_mem[sel_idx][{wb_adr_i[3:2], 2'(k)}] <= wb_dat_i[8*k +: 8];
					end
				end
			end
			if (tx_done_ok && ctrl[CMB_CTRL_TS]) begin
				tx_mem[cur][CMB_TX_TS_HI] <= bit_timer[15:8];
				tx_mem[cur][CMB_TX_TS_LO] <= bit_timer[7:0];
			end
		end
	end

	// Engine view: busy flag, buffer index, one-cycle latency byte read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_busy_o <= 1'b0;
			tx_idx_o  <= 2'h0;
			tx_byte_o <= 8'h00;
		end else begin
			tx_busy_o <= sending;
			tx_idx_o  <= cur;
			tx_byte_o <= tx_mem[cur][eng_tx_rd_addr_i];
		end
	end

	// ==========================================================
	// Receive side
	// ==========================================================
	// Background always captures the bus, own frames included, until overwritten
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bg_buf <= '0;
		end else begin
			if (eng_rx_we_i && eng_rx_addr_i < 4'(CMB_RX_BYTES)) begin
				bg_buf[eng_rx_addr_i] <= eng_rx_data_i;
			end
			if (eng_rx_end_i) begin
				bg_buf <= bg_final;
			end
		end
	end

	// FIFO stages in arrival order; overrun drops the newcomer only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_count <= 3'h0;
			rd_ptr   <= 3'h0;
			wr_ptr   <= 3'h0;
			for (int i = 0; i < CMB_RX_DEPTH; i++) begin
				rx_mem[i] <= '0;
			end
		end else begin
			if (push) begin
				rx_mem[wr_ptr] <= bg_final;
				wr_ptr <= (wr_ptr == CMB_RX_DEPTH_W - 3'h1) ? 3'h0 : wr_ptr + 3'h1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == CMB_RX_DEPTH_W - 3'h1) ? 3'h0 : rd_ptr + 3'h1;
			end
			rx_count <= rx_count + {2'h0, push} - {2'h0, pop};
		end
	end

	// Overrun flag: host clears by writing one, a new overrun wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_flag <= 1'b0;
		end else if (commit && !push) begin
			ovr_flag <= 1'b1;
		end else if (wr_now && wb_adr_i == CMB_RX_FLAG && wb_sel_i[0]
			&& wb_dat_i[CMB_OVR_BIT]) begin
			ovr_flag <= 1'b0;
		end
	end

	// ==========================================================
	// Interrupt lines
	// ==========================================================
	// Levels follow their flags, so polling and interrupts see the same state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_int_o  <= 1'b0;
			rx_int_o  <= 1'b0;
			ovr_int_o <= 1'b0;
		end else begin
			tx_int_o  <= |(tx_empty & ctrl[CMB_CTRL_TXIE +: 3]);
			rx_int_o  <= rx_full_flag & ctrl[CMB_CTRL_RXIE];
			ovr_int_o <= ovr_flag & ctrl[CMB_CTRL_OVIE];
		end
	end

endmodule

`default_nettype wire

// [tb/cmb_store_checker.sv]
`default_nettype none
// ====================
// Port-level checks for the message buffer store
// ====================
module cmb_store_checker (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       eng_arb_i,
	input wire logic       eng_tx_done_i,
	input wire logic       eng_tx_err_i,
	input wire logic       eng_arb_lost_i,
	input wire logic       tx_busy_o,
	input wire logic [1:0] tx_idx_o,
	input wire logic       tx_int_o,
	input wire logic       rx_int_o,
	input wire logic       ovr_int_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Any of the three ways a send can end
	logic fin;
	assign fin = eng_tx_done_i | eng_tx_err_i | eng_arb_lost_i;
	// Bus answers with exactly one wait state, as a single pulse
	chk_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	// Sending starts only two cycles after an arbitration strobe
	chk_busy_after_arb: assert property ($rose(tx_busy_o) |-> $past(eng_arb_i, 2))
		else $error("send started without arbitration");
	// A frame on air is never dropped without an end event
	chk_busy_holds: assert property (tx_busy_o && !fin && !$past(fin) |=> tx_busy_o)
		else $error("send ended without done, error or loss");
	chk_done_ends: assert property (eng_tx_done_i && tx_busy_o && !$past(fin)
		|-> ##2 !tx_busy_o)
		else $error("send still busy after done");
	chk_idx_steady: assert property (tx_busy_o && $past(tx_busy_o) |-> $stable(tx_idx_o))
		else $error("buffer index changed during a send");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !tx_busy_o
		&& tx_idx_o == 2'h0 && !tx_int_o && !rx_int_o && !ovr_int_o)
		else $error("outputs not idle after reset");
endmodule

bind cmb_store cmb_store_checker u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .eng_arb_i(eng_arb_i), .eng_tx_done_i(eng_tx_done_i),
	.eng_tx_err_i(eng_tx_err_i), .eng_arb_lost_i(eng_arb_lost_i),
	.tx_busy_o(tx_busy_o), .tx_idx_o(tx_idx_o), .tx_int_o(tx_int_o),
	.rx_int_o(rx_int_o), .ovr_int_o(ovr_int_o)
);
`default_nettype wire

// [tb/cmb_eng_model.sv]
`default_nettype none
// ====================
// Protocol engine stand-in on the far side of the store
// ====================
module cmb_eng_model (
	input  wire logic              clk_i,
	input  wire cmb_pkg::cmb_byte_t tx_byte_i,
	output var  logic              arb_o,
	output var  logic              done_o,
	output var  logic              err_o,
	output var  logic              lost_o,
	output var  logic [3:0]        rd_addr_o,
	output var  logic              rx_we_o,
	output var  logic [3:0]        rx_addr_o,
	output var  cmb_pkg::cmb_byte_t rx_data_o,
	output var  logic              rx_end_o,
	output var  logic              accept_o,
	output var  logic              own_o,
	output var  logic              tick_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import cmb_pkg::*;
	logic [2:0] tick_cnt;
	// Idle levels at time zero
	initial begin
		{arb_o, done_o, err_o, lost_o, rx_we_o, rx_end_o, accept_o, own_o, tick_o} = '0;
		rd_addr_o = 4'h0;
		rx_addr_o = 4'h0;
		rx_data_o = 8'h5a;
		tick_cnt  = 3'h0;
	end
	// Bit-time tick every eight clocks keeps the stamp timer moving
	always @(posedge clk_i) begin
		tick_cnt <= tick_cnt + 3'h1;
		tick_o   <= (tick_cnt == 3'h7);
	end
	// Arbitration strobe; the store picks its buffer here
	task automatic arb();
		@(posedge clk_i);
		arb_o <= 1'b1;
		@(posedge clk_i);
		arb_o <= 1'b0;
	endtask
	// End of a send: 0 sent, 1 error, 2 lost arbitration
	task automatic tx_end(input int k);
		@(posedge clk_i);
		done_o <= (k == 0);
		err_o  <= (k == 1);
		lost_o <= (k == 2);
		@(posedge clk_i);
		{done_o, err_o, lost_o} <= 3'h0;
	endtask
	// Fetches one byte of the buffer on air, one cycle after its address
	task automatic rd_byte(input logic [3:0] a, output cmb_byte_t b);
		@(posedge clk_i);
		rd_addr_o <= a;
		@(posedge clk_i);
		@(negedge clk_i);
		b = tx_byte_i;
	endtask
	// Frame of 13 bytes s, s+1, ... then a valid end; may follow at once
	task automatic rx_frame(input cmb_byte_t s, input logic acc, input logic own);
		for (int i = 0; i < 13; i++) begin
			@(posedge clk_i);
			rx_we_o   <= 1'b1;
			rx_addr_o <= 4'(i);
			rx_data_o <= s + 8'(i);
		end
		@(posedge clk_i);
		rx_we_o   <= 1'b0;
		rx_data_o <= ~rx_data_o; // Released lines must not keep the last byte
		rx_end_o  <= 1'b1;
		accept_o  <= acc;
		own_o     <= own;
		@(posedge clk_i);
		rx_end_o  <= 1'b0;
		accept_o  <= ~acc;
		own_o     <= ~own;
	endtask
endmodule
`default_nettype wire

// [tb/cmb_store_test.sv]
`default_nettype none
// ====================
// Self-checking bench for the message buffer store
// ====================
module cmb_store_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cmb_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0, rd_addr, rx_addr;
	logic [31:0] wb_dat = 32'h0000_0000, wb_q, rd;
	logic        arb, done, err, lost, busy, rx_we, rx_end, acc, own, tick;
	logic        tx_int, rx_int, ovr_int;
	logic [1:0]  idx;
	cmb_byte_t   tx_byte, rx_data, b;
	cmb_byte_t   pr [3] = '{8'h20, 8'h10, 8'h10};
	int          errors = 0, compares = 0, cycles = 0, ticks = 0;
	logic [15:0] rx_ts = 16'h0000, tx_ts = 16'h0000;
	// Clock and hang guard
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end
	// Bit ticks since reset; the stamp is the count seen at a frame's closing edge
	always @(posedge clk_i) begin
		if (rx_end)
			rx_ts = 16'(ticks);
		if (done)
			tx_ts = 16'(ticks);
		if (!rst_i && tick)
			ticks++;
	end
	cmb_store DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_q), .wb_ack_o(wb_ack), .eng_arb_i(arb), .eng_tx_done_i(done),
		.eng_tx_err_i(err), .eng_arb_lost_i(lost), .eng_tx_rd_addr_i(rd_addr),
		.tx_busy_o(busy), .tx_idx_o(idx), .tx_byte_o(tx_byte), .eng_rx_we_i(rx_we),
		.eng_rx_addr_i(rx_addr), .eng_rx_data_i(rx_data), .eng_rx_end_i(rx_end),
		.eng_rx_accept_i(acc), .eng_rx_own_i(own), .eng_bit_tick_i(tick),
		.tx_int_o(tx_int), .rx_int_o(rx_int), .ovr_int_o(ovr_int)
	);
	cmb_eng_model eng (
		.clk_i(clk_i), .tx_byte_i(tx_byte), .arb_o(arb), .done_o(done), .err_o(err),
		.lost_o(lost), .rd_addr_o(rd_addr), .rx_we_o(rx_we), .rx_addr_o(rx_addr),
		.rx_data_o(rx_data), .rx_end_o(rx_end), .accept_o(acc), .own_o(own), .tick_o(tick)
	);
	// Classic single cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat <= d;
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		rd = wb_q;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	task automatic wait_busy();
		do @(posedge clk_i); while (busy !== 1'b1);
	endtask
	// Four frame bytes starting at s, lowest in lane 0
	function automatic logic [31:0] exp_w(input cmb_byte_t s);
		return {s + 8'h03, s + 8'h02, s + 8'h01, s};
	endfunction
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ====================
	// Test sequence
	// ====================
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(CMB_TX_FLAG, 32'h0000_0007);
		rdc(CMB_STATUS, 32'h0000_0000);
		rdc(CMB_RX_FLAG, 32'h0000_0000);
		rdc(8'h3C, 32'h0000_0000);
		$display("test reset done");
		// Load buffer i with bytes 0x40*i+n; priorities 0x20, 0x10, 0x10
		wb(1'b1, CMB_CTRL, 32'h0000_0070);
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, CMB_TX_SEL, 32'(1 << i));
			rdc(CMB_TX_SEL, 32'(1 << i));
			for (int w = 0; w < 3; w++)
				wb(1'b1, CMB_TXWIN_BASE + 8'(4 * w), exp_w(8'(64 * i + 4 * w)));
			wb(1'b1, CMB_TXWIN_BASE + 8'h0C, {16'h0000, pr[i], 8'(64 * i + 12)});
			rdc(CMB_TXWIN_BASE, exp_w(8'(64 * i)));
			rdc(CMB_TXWIN_BASE + 8'h0C, {16'h0000, pr[i], 8'(64 * i + 12)});
		end
		wb(1'b1, CMB_TX_FLAG, 32'h0000_0007);
		rdc(CMB_TX_FLAG, 32'h0000_0000);
		chk(32'(tx_int), 32'h0);
		// Tie on lowest priority goes to buffer 1; abort waits while on air
		eng.arb();
		wait_busy();
		chk(32'(idx), 32'h1);
		eng.rd_byte(4'h0, b);
		chk(32'(b), 32'h40);
		wb(1'b1, CMB_ABT_REQ, 32'h0000_0002);
		rdc(CMB_ABT_ACK, 32'h0000_0000);
		eng.tx_end(1);
		rdc(CMB_ABT_ACK, 32'h0000_0002);
		rdc(CMB_TX_FLAG, 32'h0000_0002);
		// Re-pick after error, then lose and receive the winner
		eng.arb();
		wait_busy();
		chk(32'(idx), 32'h2);
		eng.tx_end(2);
		eng.rx_frame(8'h00, 1'b1, 1'b0);
		eng.arb();
		wait_busy();
		chk(32'(idx), 32'h2);
		eng.tx_end(0);
		rdc(CMB_TX_FLAG, 32'h0000_0006);
		rdc(CMB_ABT_ACK, 32'h0000_0002);
		chk(32'(tx_int), 32'h1);
		$display("test transmit done");
		// Own and rejected frames stay out; loopback frame goes in
		wb(1'b1, CMB_CTRL, 32'h0000_000E);
		eng.rx_frame(8'hA0, 1'b1, 1'b1);
		eng.rx_frame(8'hB0, 1'b0, 1'b0);
		rdc(CMB_STATUS, 32'h0000_000A);
		wb(1'b1, CMB_CTRL, 32'h0000_000F);
		eng.rx_frame(8'h10, 1'b1, 1'b1);
		wb(1'b1, CMB_CTRL, 32'h0000_000E);
		rdc(CMB_STATUS, 32'h0000_0012);
		for (int k = 2; k < 5; k++)
			eng.rx_frame(8'(16 * k), 1'b1, 1'b0);
		rdc(CMB_RX_FLAG, 32'h0000_0001);
		chk({30'h0, rx_int, ovr_int}, 32'h2);
		// Sixth frame overruns; sending still works while full
		eng.rx_frame(8'h50, 1'b1, 1'b0);
		rdc(CMB_RX_FLAG, 32'h0000_0003);
		chk(32'(ovr_int), 32'h1);
		rdc(CMB_STATUS, 32'h0000_002A);
		eng.arb();
		wait_busy();
		chk(32'(idx), 32'h0);
		eng.tx_end(0);
		rdc(CMB_TX_FLAG, 32'h0000_0007);
		wb(1'b1, CMB_TX_SEL, 32'h0000_0001);
		rdc(CMB_TXWIN_BASE + 8'h0C, {tx_ts[7:0], tx_ts[15:8], 8'h20, 8'h0C});
		// Pop one, accept again, then drain in arrival order
		rdc(CMB_RXWIN_BASE, exp_w(8'h00));
		wb(1'b1, CMB_RX_FLAG, 32'h0000_0003);
		eng.rx_frame(8'h60, 1'b1, 1'b0);
		for (int k = 1; k < 6; k++) begin
			rdc(CMB_RXWIN_BASE, exp_w(k < 5 ? 8'(16 * k) : 8'h60));
			if (k == 5)
				rdc(CMB_RXWIN_BASE + 8'h0C, {8'h00, rx_ts[7:0], rx_ts[15:8], 8'h6C});
			wb(1'b1, CMB_RX_FLAG, 32'h0000_0001);
		end
		rdc(CMB_RX_FLAG, 32'h0000_0000);
		rdc(CMB_STATUS, 32'h0000_0000);
		chk({30'h0, rx_int, ovr_int}, 32'h0);
		$display("test receive done");
		wrap_up();
	end
endmodule
`default_nettype wire
